// ==== hdl/alarm_wd_map.svh ====
// Register indices, field positions, reset values and cycle counts of the alarm and watchdog block.
`ifndef ALARM_WD_MAP_SVH
`define ALARM_WD_MAP_SVH

`define IDX_CONTROL 6'h08
`define IDX_WD_CONTROL 6'h0a
`define IDX_A0_SECONDS 6'h0c
`define IDX_A0_MINUTES 6'h0d
`define IDX_A0_HOURS 6'h0e
`define IDX_A0_WEEKDAY 6'h0f
`define IDX_A0_DATE 6'h10
`define IDX_A0_MONTH 6'h11
`define IDX_A1_HUNDREDTHS 6'h12
`define IDX_A1_SECONDS 6'h13
`define IDX_A1_MINUTES 6'h14
`define IDX_A1_HOURS 6'h15
`define IDX_A1_WEEKDAY 6'h16
`define IDX_A1_DATE 6'h17

`define CTRL_FIRST_ALARM_ENABLE 4
`define CTRL_SECOND_ALARM_ENABLE 5
`define ALM_PIN_BIT 7
`define ALM_MASK_MSB 6
`define ALM_MASK_LSB 4
`define ALM_FLAG_BIT 3
`define WD_ENABLE_BIT 7
`define WD_FLAG_BIT 6
`define WD_DELAY_BIT 5
`define WD_PWS_BIT 4

`define MASK_SECONDS 3'h0
`define MASK_MINUTES 3'h1
`define MASK_HOURS 3'h2
`define MASK_WEEKDAY 3'h3
`define MASK_DATE 3'h4
`define MASK_HUNDREDTHS 3'h5
`define MASK_ALL 3'h7

`define RST_WEEKDAY_REG 8'h01
`define RST_DATE 6'h01
`define RST_MONTH 5'h01

`define WD_PERIOD_0 22'h000020
`define WD_PERIOD_1 22'h000200
`define WD_PERIOD_2 22'h000800
`define WD_PERIOD_3 22'h001000
`define WD_PERIOD_4 32768
`define WD_PERIOD_5 524288
`define WD_PERIOD_6 1048576
`define WD_PERIOD_7 2097152
`define WD_DELAY_CYCLES 2097152
`define WD_PULSE_SHORT 13'h0004
`define WD_PULSE_LONG 13'h1000

`endif

// ==== hdl/alarm_wd_pkg.sv ====
// Types shared by the alarm and watchdog block.
package alarm_wd_pkg;

    typedef struct packed {
        logic [7:0] hundredths;
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [6:0] hours;
        logic [2:0] weekday;
        logic [5:0] date;
        logic [4:0] month;
    } time_values_t;

    typedef struct packed {
        logic alarm_pin_select;
        logic [2:0] alarm_match_mask;
        logic alarm_flag;
        logic [2:0] weekday_value;
    } alarm_config_t;

    typedef enum logic [3:0] {
        WD_IDLE = 4'b0001,
        WD_DELAY = 4'b0010,
        WD_COUNT = 4'b0100,
        WD_HALT = 4'b1000
    } wd_state_t;

endpackage : alarm_wd_pkg

// ==== hdl/alarm_match_and_watchdog.sv ====
// Two calendar alarm comparators and a watchdog timer behind an APB register slave.
// How it works
// - Alarm pin-select bit 1 routes its flag to the watchdog pin, 0 to interrupt.
// - Three-bit mask picks seconds, minutes, hours, weekday, date, hundredths or all.
// - Hours compare includes the afternoon indicator in the format currently in effect.
// - Hundredths matching exists on the second alarm only; first alarm code reserved.
// - Full match includes month on the first alarm only.
// - A match sets the alarm flag, which stays set until software clears it.
// - Writing zero clears an alarm flag; writing one never sets it.
// - Alarm date is BCD: tens 0-3 in bits 5-4, ones in bits 3-0.
// - First alarm month is BCD: tens bit 4, ones in bits 3-0.
// - Upper unused bits of date and month registers read zero.
// - An alarm compares only while its enable bit in control is set.
// - The enabled watchdog counts oscillator cycles upward toward its period.
// - On time-out the watchdog flag sets and the watchdog pin pulses low.
// - Four-bit period select chooses 32 to 2097152 cycles; top-bit codes reserved.
// - With delay enabled, every restart or clear first waits the start-up delay.
// - The delay is 2097152 oscillator cycles; clearing delay-enable removes it.
// - After time-out the watchdog halts until software clears its flag.
// - Only oscillator ticks advance the watchdog; no ticks means no time-out.
// - Pulse-width bit gives 4096 cycles when set, 4 cycles when clear.
// - Running from backup supply clears the watchdog enable bit.
//
// Added by the designer: the APB register port.
`include "alarm_wd_map.svh"

module alarm_match_and_watchdog #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 22,
    parameter int PERIOD_4 = `WD_PERIOD_4,
    parameter int PERIOD_5 = `WD_PERIOD_5,
    parameter int PERIOD_6 = `WD_PERIOD_6,
    parameter int PERIOD_7 = `WD_PERIOD_7,
    parameter int DELAY_CYCLES = `WD_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_tick,
    input wire logic time_update,
    input wire alarm_wd_pkg::time_values_t current_time,
    input wire logic on_backup,
    input wire logic watchdog_clear,
    output logic irq_n,
    output logic watchdog_out_n
);

    if (ADDR_W < 8 || CNT_W < 22 || CNT_W > 31 || DELAY_CYCLES < 1 || PERIOD_4 < 1
            || PERIOD_7 >= (1 << CNT_W) || DELAY_CYCLES >= (1 << CNT_W)) begin : g_check
        $error("alarm_match_and_watchdog: parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Register storage.
    alarm_wd_pkg::alarm_config_t alarm_cfg [2];
    logic [6:0] alarm_seconds [2];
    logic [6:0] alarm_minutes [2];
    logic [5:0] alarm_hours [2];
    logic [5:0] alarm_date [2];
    logic [4:0] alarm0_month;
    logic [7:0] alarm1_hundredths;
    logic [7:0] shared_control;
    logic [7:0] wd_control;
    logic [1:0] alarm_enable;
    logic [1:0] match;
    logic [1:0] prev_match;
    logic [1:0] alarm_set;
    logic [5:0] idx;
    logic access;
    logic wr;
    logic [31:0] rd_data;
    logic rd_hit;
    alarm_wd_pkg::wd_state_t wd_state;
    logic [CNT_W-1:0] wd_count;
    logic [CNT_W-1:0] wd_period;
    logic wd_expire;
    logic [12:0] pulse_left;

    localparam logic [5:0] SEC_IDX [2] = '{`IDX_A0_SECONDS, `IDX_A1_SECONDS};
    localparam logic [5:0] MIN_IDX [2] = '{`IDX_A0_MINUTES, `IDX_A1_MINUTES};
    localparam logic [5:0] HOUR_IDX [2] = '{`IDX_A0_HOURS, `IDX_A1_HOURS};
    localparam logic [5:0] WK_IDX [2] = '{`IDX_A0_WEEKDAY, `IDX_A1_WEEKDAY};
    localparam logic [5:0] DATE_IDX [2] = '{`IDX_A0_DATE, `IDX_A1_DATE};

    assign idx = paddr[7:2];
    assign access = psel & penable;
    assign wr = access & pready & pwrite;
    assign alarm_enable = {shared_control[`CTRL_SECOND_ALARM_ENABLE],
                           shared_control[`CTRL_FIRST_ALARM_ENABLE]};

    ////////////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, then ready with data and error for one cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            prdata <= (access & ~pready & ~pwrite & rd_hit) ? rd_data : 32'h0000_0000;
            pslverr <= access & ~pready & ~rd_hit;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
        if (idx == `IDX_CONTROL) begin
            rd_data[7:0] = shared_control;
        end else if (idx == `IDX_WD_CONTROL) begin
            rd_data[7:0] = wd_control;
        end else if (idx == `IDX_A0_SECONDS || idx == `IDX_A1_SECONDS) begin
            rd_data[6:0] = alarm_seconds[idx == `IDX_A1_SECONDS];
        end else if (idx == `IDX_A0_MINUTES || idx == `IDX_A1_MINUTES) begin
            rd_data[6:0] = alarm_minutes[idx == `IDX_A1_MINUTES];
        end else if (idx == `IDX_A0_HOURS || idx == `IDX_A1_HOURS) begin
            rd_data[7:0] = {1'b0, current_time.hours[6], alarm_hours[idx == `IDX_A1_HOURS]};
        end else if (idx == `IDX_A0_WEEKDAY || idx == `IDX_A1_WEEKDAY) begin
            rd_data[7:0] = alarm_cfg[idx == `IDX_A1_WEEKDAY];
        end else if (idx == `IDX_A0_DATE || idx == `IDX_A1_DATE) begin
            rd_data[5:0] = alarm_date[idx == `IDX_A1_DATE];
        end else if (idx == `IDX_A0_MONTH) begin
            rd_data[4:0] = alarm0_month;
        end else if (idx == `IDX_A1_HUNDREDTHS) begin
            rd_data[7:0] = alarm1_hundredths;
        end else begin
            rd_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Alarm match values.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 2; i++) begin
                alarm_seconds[i] <= 7'h00;
                alarm_minutes[i] <= 7'h00;
                alarm_hours[i] <= 6'h00;
                alarm_date[i] <= `RST_DATE;
            end
            alarm0_month <= `RST_MONTH;
            alarm1_hundredths <= 8'h00;
        end else if (wr) begin
            for (int i = 0; i < 2; i++) begin
                if (idx == SEC_IDX[i]) begin
                    alarm_seconds[i] <= pwdata[6:0];
                end
                if (idx == MIN_IDX[i]) begin
                    alarm_minutes[i] <= pwdata[6:0];
                end
                if (idx == HOUR_IDX[i]) begin
                    alarm_hours[i] <= pwdata[5:0];
                end
                if (idx == DATE_IDX[i]) begin
                    alarm_date[i] <= pwdata[5:0];
                end
            end
            // BCD month tens bit and ones
            if (idx == `IDX_A0_MONTH) begin
                alarm0_month <= pwdata[4:0];
            end
            if (idx == `IDX_A1_HUNDREDTHS) begin
                alarm1_hundredths <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Alarm configuration and sticky flags; a hardware set wins over a software clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 2; i++) begin
                alarm_cfg[i] <= `RST_WEEKDAY_REG;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr && idx == WK_IDX[i]) begin
                    alarm_cfg[i].alarm_pin_select <= pwdata[`ALM_PIN_BIT];
                    alarm_cfg[i].alarm_match_mask <= pwdata[`ALM_MASK_MSB:`ALM_MASK_LSB];
                    alarm_cfg[i].weekday_value <= pwdata[2:0];
                    alarm_cfg[i].alarm_flag <= alarm_set[i]
                        | (alarm_cfg[i].alarm_flag & pwdata[`ALM_FLAG_BIT]);
                end else if (alarm_set[i]) begin
                    alarm_cfg[i].alarm_flag <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shared_control <= 8'h00;
        end else if (wr && idx == `IDX_CONTROL) begin
            shared_control <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Per-alarm comparators.
    for (genvar g = 0; g < 2; g++) begin : g_alarm
        logic hit;
        logic month_ok;
        logic hsec_ok;
        always_comb begin
            // month only on the first alarm
            month_ok = (g == 0) ? (current_time.month == alarm0_month) : 1'b1;
            // hundredths only on the second alarm
            hsec_ok = (g == 1) && (current_time.hundredths == alarm1_hundredths);
            case (alarm_cfg[g].alarm_match_mask)
                `MASK_SECONDS: hit = current_time.seconds == alarm_seconds[g];
                `MASK_MINUTES: hit = current_time.minutes == alarm_minutes[g];
                // afternoon indicator and tens compared together
                `MASK_HOURS: hit = current_time.hours[5:0] == alarm_hours[g];
                `MASK_WEEKDAY: hit = current_time.weekday == alarm_cfg[g].weekday_value;
                `MASK_DATE: hit = current_time.date == alarm_date[g];
                `MASK_HUNDREDTHS: hit = hsec_ok;
                `MASK_ALL: hit = (current_time.seconds == alarm_seconds[g])
                    && (current_time.minutes == alarm_minutes[g])
                    && (current_time.hours[5:0] == alarm_hours[g])
                    && (current_time.weekday == alarm_cfg[g].weekday_value)
                    && (current_time.date == alarm_date[g]) && month_ok;
                default: hit = 1'b0;
            endcase
        end
        assign match[g] = hit;
        // set once on the update where the match begins
        assign alarm_set[g] = alarm_enable[g] & time_update & hit & ~prev_match[g];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_match <= 2'b00;
        end else if (time_update) begin
            prev_match <= match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Watchdog control register.
    always_ff @(posedge clk) begin
        if (reset) begin
            wd_control <= 8'h00;
        end else begin
            if (wr && idx == `IDX_WD_CONTROL) begin
                wd_control <= pwdata[7:0];
                wd_control[`WD_FLAG_BIT] <= wd_expire
                    | (wd_control[`WD_FLAG_BIT] & pwdata[`WD_FLAG_BIT]);
            end else if (wd_expire) begin
                wd_control[`WD_FLAG_BIT] <= 1'b1;
            end
            if (on_backup) begin
                wd_control[`WD_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // period lookup, reserved codes take the longest period
    always_comb begin
        case (wd_control[3:0])
            4'h0: wd_period = CNT_W'(`WD_PERIOD_0);
            4'h1: wd_period = CNT_W'(`WD_PERIOD_1);
            4'h2: wd_period = CNT_W'(`WD_PERIOD_2);
            4'h3: wd_period = CNT_W'(`WD_PERIOD_3);
            4'h4: wd_period = CNT_W'(PERIOD_4);
            4'h5: wd_period = CNT_W'(PERIOD_5);
            4'h6: wd_period = CNT_W'(PERIOD_6);
            default: wd_period = CNT_W'(PERIOD_7);
        endcase
    end

    // expiry only on an oscillator tick
    assign wd_expire = (wd_state == alarm_wd_pkg::WD_COUNT) && osc_tick && !watchdog_clear
        && (wd_count == wd_period - CNT_W'(1));

    ////////////////////////////////////////////////////////////////////////////////////
    // Watchdog sequencer.
    always_ff @(posedge clk) begin
        if (reset) begin
            wd_state <= alarm_wd_pkg::WD_IDLE;
            wd_count <= '0;
        end else if (!wd_control[`WD_ENABLE_BIT]) begin
            // disable returns count and delay to zero
            wd_state <= alarm_wd_pkg::WD_IDLE;
            wd_count <= '0;
        end else begin
            case (wd_state)
                alarm_wd_pkg::WD_IDLE: begin
                    wd_count <= '0;
                    wd_state <= wd_control[`WD_DELAY_BIT] ? alarm_wd_pkg::WD_DELAY
                                                          : alarm_wd_pkg::WD_COUNT;
                end
                alarm_wd_pkg::WD_DELAY: begin
                    if (watchdog_clear) begin
                        wd_count <= '0;
                    end else if (!wd_control[`WD_DELAY_BIT]) begin
                        wd_count <= '0;
                        wd_state <= alarm_wd_pkg::WD_COUNT;
                    end else if (osc_tick) begin
                        if (wd_count == CNT_W'(DELAY_CYCLES - 1)) begin
                            wd_count <= '0;
                            wd_state <= alarm_wd_pkg::WD_COUNT;
                        end else begin
                            wd_count <= wd_count + CNT_W'(1);
                        end
                    end
                end
                alarm_wd_pkg::WD_COUNT: begin
                    if (watchdog_clear) begin
                        wd_count <= '0;
                        wd_state <= wd_control[`WD_DELAY_BIT] ? alarm_wd_pkg::WD_DELAY
                                                              : alarm_wd_pkg::WD_COUNT;
                    end else if (wd_expire) begin
                        wd_count <= '0;
                        wd_state <= alarm_wd_pkg::WD_HALT;
                    end else if (osc_tick) begin
                        wd_count <= wd_count + CNT_W'(1);
                    end
                end
                alarm_wd_pkg::WD_HALT: begin
                    // restart only once the flag is cleared
                    if (!wd_control[`WD_FLAG_BIT]) begin
                        wd_state <= alarm_wd_pkg::WD_IDLE;
                    end
                end
                default: begin
                    wd_state <= alarm_wd_pkg::WD_IDLE;
                    wd_count <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Watchdog pulse width, counted in oscillator cycles.
    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_left <= 13'h0000;
        end else if (wd_expire) begin
            pulse_left <= wd_control[`WD_PWS_BIT] ? `WD_PULSE_LONG : `WD_PULSE_SHORT;
        end else if (osc_tick && pulse_left != 13'h0000) begin
            pulse_left <= pulse_left - 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Output pins, both active low.
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_n <= 1'b1;
            watchdog_out_n <= 1'b1;
        end else begin
            // route each alarm flag by its pin-select bit
            irq_n <= ~((alarm_cfg[0].alarm_flag & ~alarm_cfg[0].alarm_pin_select)
                     | (alarm_cfg[1].alarm_flag & ~alarm_cfg[1].alarm_pin_select));
            // time-out pulse drives the watchdog pin low
            watchdog_out_n <= ~((pulse_left != 13'h0000)
                     | (alarm_cfg[0].alarm_flag & alarm_cfg[0].alarm_pin_select)
                     | (alarm_cfg[1].alarm_flag & alarm_cfg[1].alarm_pin_select));
        end
    end

endmodule : alarm_match_and_watchdog

// ==== tb/alarm_wd_props.sv ====
// Checker of the block's bus timing and output causes.
module alarm_wd_props #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_tick,
    input wire logic time_update,
    input wire logic irq_n,
    input wire logic watchdog_out_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    property p_one_wait;
        s_access |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("late ready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_idle_quiet;
        !psel |=> !pready;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("stray ready");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
    property p_misaligned;
        s_done ##0 paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned ok");
    property p_reset_quiet;
        disable iff (1'b0) reset |=> irq_n && watchdog_out_n && !pready && !pslverr;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs");
    property p_irq_cause;
        $fell(irq_n) |-> $past(time_update, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
    property p_irq_release;
        $rose(irq_n) |-> $past(pwrite && pready, 2) || $past(reset);
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq released");
    property p_wdo_cause;
        $fell(watchdog_out_n) |-> $past(osc_tick) || $past(osc_tick, 2)
            || $past(time_update, 2) || $past(pwrite && pready, 2);
    endproperty
    a_wdo_cause: assert property (p_wdo_cause) else $error("stray wdo");
endmodule : alarm_wd_props

bind alarm_match_and_watchdog alarm_wd_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
    .time_update(time_update), .irq_n(irq_n), .watchdog_out_n(watchdog_out_n));

// ==== tb/osc_source.sv ====
// Oscillator model giving one tick pulse every few system clocks.
module osc_source #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic run,
    output logic tick = 1'b0
);
    int cnt = 0;
    always @(posedge clk) begin
        cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
        tick <= run && (cnt == DIV - 1);
    end
endmodule : osc_source

// ==== tb/tb_top.sv ====
// Self-checking bench of the alarm and watchdog block.
`include "alarm_wd_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef alarm_wd_pkg::time_values_t tv_t;
    localparam int TAB[8] = '{32, 512, 2048, 4096, 64, 80, 96, 128};
    localparam int DLY = 40;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic time_update = 1'b0, on_backup = 1'b0, watchdog_clear = 1'b0, run = 1'b1, err;
    logic [1:0] lo_bits = 2'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, lfsr_q = 32'h83c2;
    wire [31:0] prdata;
    wire pready, pslverr, osc_tick, irq_n, watchdog_out_n;
    tv_t base = '{8'h00, 7'h00, 7'h00, 7'h00, 3'h2, 6'h01, 5'h01};
    tv_t m = '{8'h42, 7'h21, 7'h33, 7'h11, 3'h1, 6'h15, 5'h07};
    tv_t cur;
    int errors = 0, n_checks = 0, cycles = 0;
    int model_reg[64];
    alarm_match_and_watchdog #(.PERIOD_4(TAB[4]), .PERIOD_5(TAB[5]), .PERIOD_6(TAB[6]),
        .PERIOD_7(TAB[7]), .DELAY_CYCLES(DLY)) u_dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick), .time_update(time_update),
        .current_time(cur), .on_backup(on_backup), .watchdog_clear(watchdog_clear),
        .irq_n(irq_n), .watchdog_out_n(watchdog_out_n));
    osc_source #(.DIV(4)) u_osc (.clk(clk), .run(run), .tick(osc_tick));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] wmask(input int i);
        case (i)
            `IDX_CONTROL, `IDX_A1_HUNDREDTHS: return 8'hff;
            12, 13, 19, 20: return 8'h7f;
            14, 21, 16, 23: return 8'h3f;
            15, 22: return 8'hf7;
            `IDX_A0_MONTH: return 8'h1f;
            default: return 8'h00;
        endcase
    endfunction : wmask
    function automatic tv_t mix(input tv_t t, input tv_t s, input int f);
        case (f)
            0: t.seconds = s.seconds;
            1: t.minutes = s.minutes;
            2: t.hours = s.hours;
            3: t.weekday = s.weekday;
            4: t.date = s.date;
            5: t.hundredths = s.hundredths;
            default: t.month = s.month;
        endcase
        return t;
    endfunction : mix
    task summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task chk_cnt(input int got, input int exp);
        chk(33'((got < exp - 1 || got > exp + 1) ? got : exp), 33'(exp));
    endtask : chk_cnt
    task apb(input logic wr, input int idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], lo_bits};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_all;
        logic mp;
        for (int k = 0; k < 64; k++) begin
            mp = k == 8 || k == 10 || (k > 11 && k < 24);
            apb(1'b0, k, 8'h00);
            chk({err, rd}, {!mp, 24'h0, 8'(model_reg[k])});
        end
    endtask : rd_all
    task upd(input tv_t t);
        @(posedge clk);
        cur <= t;
        time_update <= 1'b1;
        @(posedge clk);
        time_update <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : upd
    task alarm_chk(input int a, input int c, input logic pin, input logic fl);
        chk(33'(irq_n), 33'(!(fl && !pin)));
        chk(33'(watchdog_out_n), 33'(!(fl && pin)));
        apb(1'b0, 15 + 7 * a, 8'h00);
        chk({err, rd}, {25'h0, pin, 3'(c), fl, 3'h1});
    endtask : alarm_chk
    task wd_start(input logic [7:0] cfg);
        apb(1'b1, `IDX_WD_CONTROL, 8'h00);
        apb(1'b1, `IDX_WD_CONTROL, cfg);
    endtask : wd_start
    task wd_measure(input int exp_to, input int exp_w);
        int n;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            while (watchdog_out_n !== 1'(p)) begin
                @(posedge clk);
                n += osc_tick;
            end
            chk_cnt(n, p ? exp_w : exp_to);
        end
    endtask : wd_measure
    ////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        int i, a, c;
        logic pin;
        logic [7:0] d;
        foreach (model_reg[k]) model_reg[k] = (k inside {15, 16, 17, 22, 23}) ? 1 : 0;
        cur <= base;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd_all();
        for (i = 8; i < 24; i++) begin
            lfsr_q = lfsr(lfsr_q);
            d = lfsr_q[7:0] & ((i == `IDX_CONTROL) ? 8'hcf : 8'hff);
            if (wmask(i) != 8'h00) begin
                apb(1'b1, i, d);
                model_reg[i] = d & wmask(i);
            end
        end
        rd_all();
        lo_bits = 2'h2;
        apb(1'b0, `IDX_CONTROL, 8'h00);
        chk({err, rd}, {1'b1, 32'h0});
        lo_bits = 2'h0;
        apb(1'b1, `IDX_A0_MONTH, 8'h07);
        apb(1'b1, `IDX_A1_HUNDREDTHS, 8'h42);
        for (a = 0; a < 2; a++) begin
            apb(1'b1, 12 + 7 * a, 8'h21);
            apb(1'b1, 13 + 7 * a, 8'h33);
            apb(1'b1, 14 + 7 * a, 8'h11);
            apb(1'b1, 16 + 7 * a, 8'h15);
            for (c = 0; c < 8; c++) begin
                if (c == 6 || (c == 5 && a == 0))
                    continue;
                pin = c[0] ^ a[0];
                apb(1'b1, `IDX_CONTROL, 8'h00);
                apb(1'b1, 15 + 7 * a, {pin, 3'(c), 4'h1});
                upd(base);
                apb(1'b1, `IDX_CONTROL, 8'h10 << a);
                upd(mix(m, base, (c == 7) ? 6 * (1 - a) : c));
                alarm_chk(a, c, pin, 1'b0);
                upd((c == 7 && a == 1) ? mix(m, base, 6) : m);
                alarm_chk(a, c, pin, 1'b1);
            end
            apb(1'b1, 15 + 7 * a, 8'h01);
        end
        for (i = 0; i < 8; i++) begin
            wd_start({4'h8, 4'(i)});
            wd_measure(TAB[i], 4);
            apb(1'b0, `IDX_WD_CONTROL, 8'h00);
            chk({err, rd}, {25'h0, 4'hc, 4'(i)});
        end
        repeat (200) @(posedge clk);
        chk(33'(watchdog_out_n), 33'h1);
        wd_start(8'h90);
        wd_measure(32, 4096);
        wd_start(8'ha0);
        wd_measure(32 + DLY, 4);
        wd_start(8'h81);
        repeat (400) @(posedge clk);
        watchdog_clear <= 1'b1;
        @(posedge clk);
        watchdog_clear <= 1'b0;
        wd_measure(512, 4);
        run <= 1'b0;
        wd_start(8'h80);
        repeat (400) @(posedge clk);
        chk(33'(watchdog_out_n), 33'h1);
        run <= 1'b1;
        wd_measure(32, 4);
        on_backup <= 1'b1;
        apb(1'b0, `IDX_WD_CONTROL, 8'h00);
        chk({31'h0, err, rd[7]}, 33'h0);
        summarize();
    end
endmodule : tb_top
